// ### verilog/config_status_register.sv
// Read-only configuration status word with two host read ports.
// Assumes all internal status inputs come from logic on sys_clk;
// the completion, initialization and mode pins are asynchronous.
`timescale 1ns/1ps
`include "config_status_defines.svh"

module config_status_register (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Host ports: index 0 parallel port, index 1 JTAG
  input  config_status_pkg::cfgReq_t      portReq [`CSR_NUM_PORTS],
  output config_status_pkg::cfgRsp_t      portRsp [`CSR_NUM_PORTS],
  // External pins
  input  wire logic                       donePin,
  input  wire logic                       initPin,
  input  wire logic [2:0]                 modePins,
  // Bus width sources
  input  wire logic                       modeSampled,
  input  wire logic                       widthDetectDone,
  input  config_status_pkg::busWidth_t    detectedWidth,
  input  wire logic                       configDone,
  input  wire logic                       accessPortEn,
  input  config_status_pkg::busWidth_t    accessPortWidth,
  input  wire logic                       pkAuthActive,
  // Start-up sequencer
  input  wire logic [2:0]                 startupPhase,
  input  wire logic                       startupFinished,
  input  wire logic                       globalHighState,
  input  wire logic                       globalWriteEnState,
  input  wire logic                       globalTristateState,
  // Error events and clear
  input  wire logic                       frameDataWrite,
  input  wire logic                       idCheckPassed,
  input  wire logic                       crcErrorEvent,
  input  wire logic                       securityEvent,
  input  wire logic                       errorClear,
  // Other internal state
  input  wire logic                       doneDriveLow,
  input  wire logic                       initFinished,
  input  wire logic                       overTemp,
  input  wire logic                       decryptorSet,
  input  wire logic [`CSR_NUM_BANKS-1:0]  bankMatch,
  input  wire logic [`CSR_NUM_BANKS-1:0]  bankUsed,
  input  wire logic [`CSR_NUM_CLKMGR-1:0] clkLock,
  input  wire logic [`CSR_NUM_CLKMGR-1:0] clkUsed
);
  import config_status_pkg::*;

  // Binary phase count to its Gray code
  function automatic logic [2:0] toGray(input logic [2:0] bin);
    toGray = bin ^ {1'b0, bin[2:1]};
  endfunction : toGray

  // Address decode shared by both host ports
  function automatic logic hitsStatus(input logic [`CSR_ADDR_W-1:0] a);
    hitsStatus = (a == `CSR_STATUS_ADDR);
  endfunction : hitsStatus

  // Pin synchronisers; first stage feeds only the second
  logic [4:0] pinMeta_r;
  logic [4:0] pinSync_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinMeta_r <= 5'h00;
      pinSync_r <= 5'h00;
    end else begin
      pinMeta_r <= {modePins, initPin, donePin};
      pinSync_r <= pinMeta_r;
    end
  end

  logic       donePinSync;
  logic       initPinSync;
  logic [2:0] modeSync;
  assign donePinSync = pinSync_r[0];
  assign initPinSync = pinSync_r[1];
  assign modeSync    = pinSync_r[4:2];

  // Mode pins caught at sampling time decide the parallel default
  logic [2:0] modeLatched_r;
  logic       modeValid_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modeLatched_r <= 3'h0;
      modeValid_r   <= 1'b0;
    end else if (modeSampled) begin
      modeLatched_r <= modeSync;
      modeValid_r   <= 1'b1;
    end
  end

  logic parallelMode;
  assign parallelMode = modeValid_r &&
                        (modeLatched_r == `CSR_MODE_PFLASH ||
                         modeLatched_r == `CSR_MODE_PHOST);

  // Width field; authentication overrides everything else
  busWidth_t widthNxt;
  always_comb begin
    if (pkAuthActive) begin
      widthNxt = BUS_X32;
    end else if (accessPortEn && configDone) begin
      widthNxt = accessPortWidth;
    end else if (widthDetectDone) begin
      widthNxt = detectedWidth;
    end else if (parallelMode) begin
      widthNxt = BUS_X8;
    end else begin
      widthNxt = BUS_X1;
    end
  end

  busWidth_t width_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      width_r <= BUS_X1;
    end else begin
      width_r <= widthNxt;
    end
  end

  // Sticky error flags; a new event beats a simultaneous clear
  logic idFail_r;
  logic crcErr_r;
  logic secErr_r;
  logic idFailEvent;
  assign idFailEvent = frameDataWrite && !idCheckPassed;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idFail_r <= 1'b0;
      crcErr_r <= 1'b0;
      secErr_r <= 1'b0;
    end else begin
      idFail_r <= idFailEvent   || (idFail_r && !errorClear);
      crcErr_r <= crcErrorEvent || (crcErr_r && !errorClear);
      secErr_r <= securityEvent || (secErr_r && !errorClear);
    end
  end

  // Unused banks and clock managers count as matched or locked
  logic [`CSR_NUM_BANKS-1:0]  bankOk;
  logic [`CSR_NUM_CLKMGR-1:0] clkOk;
  genvar gi;
  generate
    for (gi = 0; gi < `CSR_NUM_BANKS; gi++) begin : g_bank
      assign bankOk[gi] = bankMatch[gi] || !bankUsed[gi];
    end
    for (gi = 0; gi < `CSR_NUM_CLKMGR; gi++) begin : g_clk
      assign clkOk[gi] = clkLock[gi] || !clkUsed[gi];
    end
  endgenerate

  // Assemble the word; untouched positions stay zero
  logic [31:0] wordNxt;
  always_comb begin
    wordNxt = `CSR_WORD_RESET;
    wordNxt[`CSR_F_WIDTH_MSB:`CSR_F_WIDTH_LSB] = width_r;
    wordNxt[`CSR_F_PHASE_MSB:`CSR_F_PHASE_LSB] = toGray(startupPhase);
    wordNxt[`CSR_B_OVERTEMP] = overTemp;
    wordNxt[`CSR_B_SECURITY] = secErr_r;
    wordNxt[`CSR_B_IDFAIL]   = idFail_r;
    wordNxt[`CSR_B_DONE_PIN] = donePinSync;
    wordNxt[`CSR_B_DONE_REL] = !doneDriveLow;
    wordNxt[`CSR_B_INIT_PIN] = initPinSync;
    wordNxt[`CSR_B_INIT_DONE] = initFinished;
    wordNxt[`CSR_F_MODE_MSB:`CSR_F_MODE_LSB] = modeSync;
    wordNxt[`CSR_B_GHIGH]    = globalHighState;
    wordNxt[`CSR_B_GWE]      = globalWriteEnState;
    wordNxt[`CSR_B_GTS]      = globalTristateState;
    wordNxt[`CSR_B_EOS]      = startupFinished;
    wordNxt[`CSR_B_MATCH]    = &bankOk;
    wordNxt[`CSR_B_LOCK]     = &clkOk;
    wordNxt[`CSR_B_DECRYPT]  = decryptorSet;
    wordNxt[`CSR_B_CRC]      = crcErr_r;
  end

  // Registered snapshot; one cycle behind its sources
  logic [31:0] word_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      word_r <= `CSR_WORD_RESET;
    end else begin
      word_r <= wordNxt;
    end
  end

  // Each host port answers reads one cycle later; writes are dropped
  generate
    for (gi = 0; gi < `CSR_NUM_PORTS; gi++) begin : g_port
      cfgRsp_t rsp_r;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          rsp_r <= '0;
        end else begin
          rsp_r.valid <= portReq[gi].valid && !portReq[gi].write;
          rsp_r.data  <= (portReq[gi].valid && !portReq[gi].write &&
                          hitsStatus(portReq[gi].addr)) ?
                         word_r : 32'h0000_0000;
        end
      end
      assign portRsp[gi] = rsp_r;
    end
  endgenerate

endmodule : config_status_register

// ### shared/config_status_defines.svh
// Constants for the read-only configuration status word.
// Assumes the includer uses them at the widths given here.
//
// Summary of operation
// - Status word readable via parallel port and JTAG
// - Bits 26:25 report internal bus width
// - Parallel modes show x8 until detection
// - Access port width shown after configuration done
// - Public-key authentication forces x32 width
// - Bits 20:18 give start-up phase in Gray
// - Bit 15 flags data write without ID check
// - Bit 14 shows completion pin level
// - Bit 13 zero while device drives completion low
// - Bit 12 shows initialization pin level
// - Bit 11 set once initialization finished
// - Bits 10:8 show synchronised live mode pin levels
// - Bit 6 shows global write enable
// - Bit 5 zero while I/Os forced high-Z
// - Bit 4 set after end of start-up
// - Bit 3 ANDs bank matches, unused banks one
// - Bit 2 ANDs clock locks, unused ones one
// - Bit 1 shows decryptor security set
`ifndef CONFIG_STATUS_DEFINES_SVH
`define CONFIG_STATUS_DEFINES_SVH

`define CSR_ADDR_W       5
`define CSR_STATUS_ADDR  5'h07
`define CSR_WORD_RESET   32'h0000_0000
`define CSR_NUM_PORTS    2
`define CSR_NUM_BANKS    8
`define CSR_NUM_CLKMGR   4

// Mode pin codes of the byte-wide parallel modes
`define CSR_MODE_PFLASH  3'h2
`define CSR_MODE_PHOST   3'h6

// Field positions
`define CSR_F_WIDTH_MSB  26
`define CSR_F_WIDTH_LSB  25
`define CSR_F_PHASE_MSB  20
`define CSR_F_PHASE_LSB  18
`define CSR_B_OVERTEMP   17
`define CSR_B_SECURITY   16
`define CSR_B_IDFAIL     15
`define CSR_B_DONE_PIN   14
`define CSR_B_DONE_REL   13
`define CSR_B_INIT_PIN   12
`define CSR_B_INIT_DONE  11
`define CSR_F_MODE_MSB   10
`define CSR_F_MODE_LSB   8
`define CSR_B_GHIGH      7
`define CSR_B_GWE        6
`define CSR_B_GTS        5
`define CSR_B_EOS        4
`define CSR_B_MATCH      3
`define CSR_B_LOCK       2
`define CSR_B_DECRYPT    1
`define CSR_B_CRC        0

`endif

// ### shared/config_status_pkg.sv
// Types for the configuration status word block.
// Assumes config_status_defines.svh supplies the constants.
`include "config_status_defines.svh"
package config_status_pkg;

  // Internal configuration bus width codes, x1 through x32
  typedef enum logic [1:0] {
    BUS_X1,
    BUS_X8,
    BUS_X16,
    BUS_X32
  } busWidth_t;

  // One register access from a host port
  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic [`CSR_ADDR_W-1:0] addr;
  } cfgReq_t;

  // Read answer to a host port
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cfgRsp_t;

endpackage : config_status_pkg

// ### verif/config_status_register_props.sv
// Checker for the status word read ports.
// Assumes a bind to config_status_register; read data lags inputs by two edges, pkAuthActive by three.
`timescale 1ns/1ps
`include "config_status_defines.svh"
module config_status_register_props (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       rst,
  // Host ports
  input config_status_pkg::cfgReq_t      portReq [`CSR_NUM_PORTS],
  input config_status_pkg::cfgRsp_t      portRsp [`CSR_NUM_PORTS],
  // Watched status sources
  input wire logic [2:0]                 startupPhase,
  input wire logic                       doneDriveLow,
  input wire logic                       pkAuthActive,
  input wire logic [`CSR_NUM_BANKS-1:0]  bankMatch,
  input wire logic [`CSR_NUM_BANKS-1:0]  bankUsed,
  input wire logic [`CSR_NUM_CLKMGR-1:0] clkLock,
  input wire logic [`CSR_NUM_CLKMGR-1:0] clkUsed
);
  import config_status_pkg::*;
  logic [1:0] upCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Edges since reset; input history before that is not trusted
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) upCnt <= 2'h0;
    else if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
  sequence rdAny(p);
    portReq[p].valid && !portReq[p].write;
  endsequence
  sequence rd7(p);
    rdAny(p) ##0 (portReq[p].addr == `CSR_STATUS_ADDR && upCnt == 2'h3);
  endsequence
  ans_par_a: assert property (
    rdAny(0) |=> portRsp[0].valid) else $error("parallel read unanswered");
  ans_jtag_a: assert property (
    rdAny(1) |=> portRsp[1].valid) else $error("jtag read unanswered");
  write_quiet_a: assert property (
    portReq[0].valid && portReq[0].write |=> !portRsp[0].valid) else $error("write answered");
  rsvd_zero_a: assert property (
    portRsp[1].valid |-> portRsp[1].data[31:27] == 5'h00 && portRsp[1].data[24:21] == 4'h0)
    else $error("reserved bits set");
  bad_addr_a: assert property (
    rdAny(0) ##0 portReq[0].addr != `CSR_STATUS_ADDR |=> portRsp[0].data == 32'h0)
    else $error("unmapped read not zero");
  phase_gray_a: assert property (
    rd7(0) |=> portRsp[0].data[20:18] == ($past(startupPhase, 2) ^ ($past(startupPhase, 2) >> 1)))
    else $error("phase not gray");
  done_rel_a: assert property (
    rd7(1) |=> portRsp[1].data[13] == !$past(doneDriveLow, 2)) else $error("release bit wrong");
  width_pk_a: assert property (
    rd7(0) |=> !$past(pkAuthActive, 3) || portRsp[0].data[26:25] == 2'h3)
    else $error("width not forced");
  bank_and_a: assert property (
    rd7(1) |=> portRsp[1].data[3] == &($past(bankMatch, 2) | ~$past(bankUsed, 2)))
    else $error("match aggregate wrong");
  lock_and_a: assert property (
    rd7(0) |=> portRsp[0].data[2] == &($past(clkLock, 2) | ~$past(clkUsed, 2)))
    else $error("lock aggregate wrong");
endmodule : config_status_register_props
bind config_status_register config_status_register_props config_status_register_props_i (
  .sys_clk, .rst, .portReq, .portRsp, .startupPhase, .doneDriveLow, .pkAuthActive,
  .bankMatch, .bankUsed, .clkLock, .clkUsed);

// ### verif/cfg_host_model.sv
// Host model: single reads and writes on one status port.
// Assumes the bench calls its task; launches on falling edges.
`timescale 1ns/1ps
`include "config_status_defines.svh"
module cfg_host_model (
  // Clock
  input wire logic                  sys_clk,
  // Port to the device
  output config_status_pkg::cfgReq_t req,
  input config_status_pkg::cfgRsp_t  rsp
);
  import config_status_pkg::*;
  initial req = '0;
  // Status port only; no control writes, so no mask write owed
  // One access; answer taken while the one-cycle response stands
  task automatic access(input logic wr, input logic [`CSR_ADDR_W-1:0] a,
                        output logic v, output logic [31:0] d);
    @(negedge sys_clk);
    req <= '{valid: 1'b1, write: wr, addr: a};
    @(negedge sys_clk);
    v = rsp.valid;
    d = rsp.data;
    req <= '{valid: 1'b0, write: ~wr, addr: ~a}; // Idle lines scrambled
  endtask : access
endmodule : cfg_host_model

// ### verif/tb_config_status_register.sv
// Bench for the status word: drives every input, reads over both ports.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`include "config_status_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_config_status_register;
  import config_status_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  cfgReq_t portReq [`CSR_NUM_PORTS];
  cfgRsp_t portRsp [`CSR_NUM_PORTS];
  logic donePin, initPin, modeSampled, widthDetectDone, configDone, accessPortEn, pkAuthActive;
  logic startupFinished, globalHighState, globalWriteEnState, globalTristateState;
  logic frameDataWrite, idCheckPassed, crcErrorEvent, securityEvent, errorClear;
  logic doneDriveLow, initFinished, overTemp, decryptorSet, v;
  logic [2:0] modePins, startupPhase, latchedMode, errs;
  busWidth_t detectedWidth, accessPortWidth;
  logic [7:0] bankMatch, bankUsed;
  logic [3:0] clkLock, clkUsed;
  logic [31:0] d;
  int miscompares = 0;
  int check_count = 0;
  always #2 sys_clk = ~sys_clk;
  config_status_register config_status_register_i (.sys_clk, .rst, .portReq, .portRsp,
    .donePin, .initPin, .modePins, .modeSampled, .widthDetectDone, .detectedWidth,
    .configDone, .accessPortEn, .accessPortWidth, .pkAuthActive, .startupPhase,
    .startupFinished, .globalHighState, .globalWriteEnState, .globalTristateState,
    .frameDataWrite, .idCheckPassed, .crcErrorEvent, .securityEvent, .errorClear,
    .doneDriveLow, .initFinished, .overTemp, .decryptorSet, .bankMatch, .bankUsed,
    .clkLock, .clkUsed);
  for (genvar g = 0; g < 2; g++) begin : hostG
    cfg_host_model cfg_host_model_i (.sys_clk, .req(portReq[g]), .rsp(portRsp[g]));
  end
  // Expected word from the bench's own view of every input
  function automatic logic [31:0] expWord();
    logic [31:0] w;
    w = '0;
    w[26:25] = pkAuthActive ? 2'h3 : (accessPortEn && configDone) ? accessPortWidth :
      widthDetectDone ? detectedWidth :
      (latchedMode inside {`CSR_MODE_PFLASH, `CSR_MODE_PHOST}) ? 2'h1 : 2'h0;
    w[20:18] = startupPhase ^ (startupPhase >> 1);
    w[17:11] = {overTemp, errs[1], errs[2], donePin, !doneDriveLow, initPin, initFinished};
    w[10:4] = {modePins, globalHighState, globalWriteEnState, globalTristateState,
      startupFinished};
    w[3:0] = {&(bankMatch | ~bankUsed), &(clkLock | ~clkUsed), decryptorSet, errs[0]};
    return w;
  endfunction : expWord
  task automatic rdChk(input int p, input logic [4:0] a, input logic [31:0] e);
    if (p == 1) hostG[1].cfg_host_model_i.access(1'b0, a, v, d);
    else hostG[0].cfg_host_model_i.access(1'b0, a, v, d);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : rdChk
  // Wait past the pin synchronisers, then read the word
  task automatic step(input int p);
    repeat (4) @(negedge sys_clk);
    rdChk(p, `CSR_STATUS_ADDR, expWord());
  endtask : step
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
  endtask : pulse
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    {donePin, initPin, modeSampled, widthDetectDone, configDone, accessPortEn} = '0;
    {pkAuthActive, startupFinished, globalHighState, globalWriteEnState} = '0;
    {globalTristateState, frameDataWrite, idCheckPassed, crcErrorEvent, securityEvent} = '0;
    {errorClear, doneDriveLow, initFinished, overTemp, decryptorSet} = '0;
    {modePins, startupPhase, latchedMode, errs, bankMatch, bankUsed, clkLock, clkUsed} = '0;
    detectedWidth = BUS_X1;
    accessPortWidth = BUS_X8;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    // Every phase, with pins and flags toggled between reads on both ports
    for (int i = 0; i < 8; i++) begin
      startupPhase = i[2:0];
      modePins = ~i[2:0];
      {donePin, initPin, doneDriveLow, initFinished, overTemp, decryptorSet, globalHighState,
        globalWriteEnState, globalTristateState, startupFinished} =
        10'(10'h155 >> i[0]) ^ {10{i[1]}};
      bankMatch = 8'h0F;
      bankUsed = {3'h0, i[2], 4'hF};
      clkLock = 4'h5;
      clkUsed = i[1] ? 4'h5 : 4'h7;
      step(i % 2);
    end
    // Width source priority
    for (int m = 0; m < 2; m++) begin
      modePins = m[0] ? `CSR_MODE_PHOST : `CSR_MODE_PFLASH;
      latchedMode = modePins;
      repeat (3) @(negedge sys_clk);
      pulse(modeSampled);
      modePins = 3'h0;
      step(0);
    end
    widthDetectDone = 1'b1;
    detectedWidth = BUS_X16;
    step(0);
    {configDone, accessPortEn} = 2'b11;
    step(0);
    pkAuthActive = 1'b1;
    step(0);
    // Sticky errors: passed identity check, then each fault, then clears
    idCheckPassed = 1'b1;
    pulse(frameDataWrite);
    step(1);
    idCheckPassed = 1'b0;
    pulse(frameDataWrite);
    pulse(crcErrorEvent);
    pulse(securityEvent);
    errs = 3'h7;
    step(1);
    crcErrorEvent = 1'b1;
    pulse(errorClear);
    crcErrorEvent = 1'b0;
    errs = 3'h1;
    step(0);
    pulse(errorClear);
    errs = 3'h0;
    step(0);
    // Write refused, unmapped address reads zero
    hostG[0].cfg_host_model_i.access(1'b1, `CSR_STATUS_ADDR, v, d);
    `CHK(v, 1'b0)
    step(1);
    rdChk(0, 5'h06, 32'h0);
    test_done();
  end
  // Tests need well under 1000 cycles
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule : tb_config_status_register
